// File: rdtpb_pkg.sv
// shared constants, field layouts and bus types for the reload timer block
package rdtpb_pkg;
  localparam int          ADDR_W      = 8;
  localparam int          CNT_W       = 10;
  localparam logic [7:0]  OFF_CTRL1   = 8'h00;
  localparam logic [7:0]  OFF_CTRL2   = 8'h04;
  localparam logic [7:0]  OFF_HIGH    = 8'h08;
  localparam logic [7:0]  OFF_RELOAD  = 8'h0c;
  localparam logic [7:0]  OFF_DUTY    = 8'h10;
  localparam logic [7:0]  OFF_PSVAL   = 8'h14;
  localparam logic [7:0]  OFF_BUZZ    = 8'h18;
  localparam logic [7:0]  OFF_IRQ     = 8'h1c;
  localparam logic [7:0]  RST_CTRL1   = 8'h00;
  localparam logic [7:0]  RST_CTRL2   = 8'h08;
  localparam logic [7:0]  RST_HIGH    = 8'h00;
  localparam logic [7:0]  RST_BUZZ    = 8'h0f;
  localparam logic [9:0]  FULL_SCALE  = 10'h3ff;
  localparam int          HI_RELOAD_LSB = 4;
  localparam int          HI_DUTY_LSB   = 0;
  localparam int          IRQ_FLAG_BIT  = 0;
  localparam int          IRQ_IE_BIT    = 1;
  localparam int          IRQ_GIE_BIT   = 2;
  localparam int          INSTR_DIV     = 4;

  typedef struct packed {
    logic       pwmOutputEnable;
    logic       pwmActiveLow;
    logic [2:0] unused;
    logic       oneShotSelect;
    logic       reloadSelect;
    logic       timerEnable;
  } rdtpb_ctrl1_t;

  typedef struct packed {
    logic [1:0] unused;
    logic       clockSourceSelect;
    logic       externalEdgeSelect;
    logic       prescalerEnable_n;
    logic [2:0] prescalerRatioSelect;
  } rdtpb_ctrl2_t;

  typedef struct packed {
    logic       buzzerEnable;
    logic [2:0] unused;
    logic [3:0] buzzerFrequencySelect;
  } rdtpb_buzz_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } rdtpb_apb_req_t;

  // low (sel+1) bits set: ratio 1:2 for sel 0 up to 1:256 for sel 7
  function automatic logic [7:0] ratio_mask(input logic [2:0] sel);
    logic [8:0] full;
    full = 9'h002 << sel;
    ratio_mask = 8'(full - 9'h001);
  endfunction : ratio_mask
endpackage : rdtpb_pkg

// File: rdtpb_prescaler.sv
// power-of-two prescaler with readable count and bypass
module rdtpb_prescaler (
  input  wire logic       clock,
  input  wire logic       sysRst,
  input  wire logic       srcTick,
  input  wire logic       enable_n,
  input  wire logic [2:0] ratioSelect,
  output logic            outTick,
  output logic [7:0]      count
);
  logic [7:0] mask;

  assign mask = rdtpb_pkg::ratio_mask(ratioSelect);

  always_ff @(posedge clock) begin
    if (sysRst) begin
      count <= 8'h00;
    end else if (srcTick) begin
      count <= count + 8'h01;
    end
  end

  // a bypassed prescaler passes every source tick straight through
  always_comb begin
    if (enable_n) begin
      outTick = srcTick;
    end else begin
      outTick = srcTick && ((count & mask) == mask);
    end
  end
endmodule : rdtpb_prescaler

// File: rdtpb_timer.sv
// reload down timer with pwm and buzzer on a shared pin, apb registers
//
// Decided for this implementation: the register addresses and register access over APB.

module rdtpb_timer #(
  parameter int INSTR_DIV = rdtpb_pkg::INSTR_DIV
) (
  input  wire logic                   clock,
  input  wire logic                   sys_rst,
  input  wire rdtpb_pkg::rdtpb_apb_req_t apbReq,
  output logic                        pready,
  output logic [31:0]                 prdata,
  output logic                        pslverr,
  input  wire logic                   externalClockInput,
  output logic                        sharedOutputPin,
  output logic                        sharedOutputPinOe,
  output logic                        pwmOutput,
  output logic                        buzzerOutput,
  output logic                        irqRequest,
  output logic                        underflowFlag
);
  rdtpb_pkg::rdtpb_ctrl1_t ctrl1;
  rdtpb_pkg::rdtpb_ctrl2_t ctrl2;
  rdtpb_pkg::rdtpb_buzz_t  buzz;
  logic [7:0]  sharedHighBitsReg;
  logic [7:0]  reloadLowByte;
  logic [7:0]  dutyLowByte;
  logic [9:0]  count;
  logic [9:0]  reloadValue;
  logic [9:0]  pwmDutyValue;
  logic        reloadPending;
  logic        underflowIrqEnable;
  logic        globalIrqEnable;
  logic [7:0]  instrCnt;
  logic        instrTick;
  logic [2:0]  extSync;
  logic        extTick;
  logic        srcTick;
  logic        timerTick;
  logic [7:0]  prescalerCountValue;
  logic        underflow;
  logic        busWrite;
  logic        busSetup;
  logic        mapped;
  logic        pwmActive;
  logic        buzzerLevel;
  logic [9:0]  next_count;

  assign busSetup = apbReq.psel && !apbReq.penable;
  assign busWrite = apbReq.psel && apbReq.penable && pready
                    && apbReq.pwrite;

  // instruction clock as an enable pulse from a divider
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      instrCnt <= 8'h00;
    end else if (instrCnt == 8'(INSTR_DIV - 1)) begin
      instrCnt <= 8'h00;
    end else begin
      instrCnt <= instrCnt + 8'h01;
    end
  end
  assign instrTick = (instrCnt == 8'(INSTR_DIV - 1));

  // pin is asynchronous: two flops, then edge detect on the second
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      extSync <= 3'h0;
    end else begin
      extSync <= {extSync[1:0], externalClockInput};
    end
  end

  always_comb begin
    if (ctrl2.externalEdgeSelect) begin
      extTick = extSync[2] && !extSync[1];
    end else begin
      extTick = !extSync[2] && extSync[1];
    end
  end

  // source gated by enable so a stopped timer freezes its prescaler too
  assign srcTick = ctrl1.timerEnable
                   && (ctrl2.clockSourceSelect ? extTick : instrTick);

  rdtpb_prescaler u_prescaler (
    .clock       (clock),
    .sysRst      (sys_rst),
    .srcTick     (srcTick),
    .enable_n    (ctrl2.prescalerEnable_n),
    .ratioSelect (ctrl2.prescalerRatioSelect),
    .outTick     (timerTick),
    .count       (prescalerCountValue)
  );

  assign underflow = timerTick && (count == 10'h000);
  assign mapped = apbReq.paddr == rdtpb_pkg::OFF_CTRL1
               || apbReq.paddr == rdtpb_pkg::OFF_CTRL2
               || apbReq.paddr == rdtpb_pkg::OFF_HIGH
               || apbReq.paddr == rdtpb_pkg::OFF_RELOAD
               || apbReq.paddr == rdtpb_pkg::OFF_DUTY
               || apbReq.paddr == rdtpb_pkg::OFF_PSVAL
               || apbReq.paddr == rdtpb_pkg::OFF_BUZZ
               || apbReq.paddr == rdtpb_pkg::OFF_IRQ;

  // control register one; one-shot drops the enable at its underflow
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl1 <= rdtpb_pkg::RST_CTRL1;
    end else begin
      if (busWrite && apbReq.paddr == rdtpb_pkg::OFF_CTRL1) begin
        ctrl1 <= apbReq.pwdata[7:0];
      end
      if (underflow && ctrl1.oneShotSelect) begin
        ctrl1.timerEnable <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl2 <= rdtpb_pkg::RST_CTRL2;
      buzz  <= rdtpb_pkg::RST_BUZZ;
    end else if (busWrite) begin
      if (apbReq.paddr == rdtpb_pkg::OFF_CTRL2) begin
        ctrl2 <= apbReq.pwdata[7:0];
      end
      if (apbReq.paddr == rdtpb_pkg::OFF_BUZZ) begin
        buzz <= apbReq.pwdata[7:0];
      end
    end
  end

  // buffered bytes; high bits wait in the shared register until reload low write, or until underflow for duty
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sharedHighBitsReg <= rdtpb_pkg::RST_HIGH;
      reloadLowByte     <= 8'h00;
      dutyLowByte       <= 8'h00;
    end else if (busWrite) begin
      if (apbReq.paddr == rdtpb_pkg::OFF_HIGH) begin
        sharedHighBitsReg <= apbReq.pwdata[7:0];
      end
      if (apbReq.paddr == rdtpb_pkg::OFF_RELOAD) begin
        reloadLowByte <= apbReq.pwdata[7:0];
      end
      if (apbReq.paddr == rdtpb_pkg::OFF_DUTY) begin
        dutyLowByte <= apbReq.pwdata[7:0];
      end
    end
  end

  // reload buffer completes on the low byte write
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reloadValue   <= 10'h000;
      reloadPending <= 1'b0;
    end else if (busWrite && apbReq.paddr == rdtpb_pkg::OFF_RELOAD) begin
      reloadValue <= {sharedHighBitsReg[rdtpb_pkg::HI_RELOAD_LSB +: 2],
                      apbReq.pwdata[7:0]};
      reloadPending <= ctrl1.timerEnable;
    end else if (underflow) begin
      reloadPending <= 1'b0;
    end
  end

  always_comb begin
    next_count = count;
    if (busWrite && apbReq.paddr == rdtpb_pkg::OFF_RELOAD
        && !ctrl1.timerEnable) begin
      next_count = {sharedHighBitsReg[rdtpb_pkg::HI_RELOAD_LSB +: 2],
                    apbReq.pwdata[7:0]};
    end else if (underflow) begin
      if (ctrl1.oneShotSelect) begin
        next_count = 10'h000;
      end else if (reloadPending || ctrl1.reloadSelect) begin
        next_count = reloadValue;
      end else begin
        next_count = rdtpb_pkg::FULL_SCALE;
      end
    end else if (timerTick) begin
      next_count = count - 10'h001;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      count <= 10'h000;
    end else begin
      count <= next_count;
    end
  end

  // duty takes effect only at a frame boundary so a frame is never torn
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pwmDutyValue <= 10'h000;
    end else if (underflow) begin
      pwmDutyValue <= {sharedHighBitsReg[rdtpb_pkg::HI_DUTY_LSB +: 2],
                       dutyLowByte};
    end
  end

  // interrupt flag: the underflow set wins over a same-cycle clear
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      underflowFlag      <= 1'b0;
      underflowIrqEnable <= 1'b0;
      globalIrqEnable    <= 1'b0;
    end else begin
      if (underflow) begin
        underflowFlag <= 1'b1;
      end else if (busWrite && apbReq.paddr == rdtpb_pkg::OFF_IRQ
                   && !apbReq.pwdata[rdtpb_pkg::IRQ_FLAG_BIT]) begin
        underflowFlag <= 1'b0;
      end
      if (busWrite && apbReq.paddr == rdtpb_pkg::OFF_IRQ) begin
        underflowIrqEnable <= apbReq.pwdata[rdtpb_pkg::IRQ_IE_BIT];
        globalIrqEnable    <= apbReq.pwdata[rdtpb_pkg::IRQ_GIE_BIT];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irqRequest <= 1'b0;
    end else begin
      irqRequest <= underflowFlag && underflowIrqEnable
                    && globalIrqEnable;
    end
  end

  // zero count ends the frame, so duty 3ff is active for 1023 ticks
  assign pwmActive = (count != 10'h000) && (count <= pwmDutyValue);

  always_comb begin
    if (buzz.buzzerFrequencySelect[3]) begin
      buzzerLevel = count[buzz.buzzerFrequencySelect[2:0]];
    end else begin
      buzzerLevel = prescalerCountValue[buzz.buzzerFrequencySelect[2:0]];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pwmOutput    <= 1'b0;
      buzzerOutput <= 1'b0;
    end else begin
      pwmOutput    <= pwmActive ^ ctrl1.pwmActiveLow;
      buzzerOutput <= buzzerLevel && buzz.buzzerEnable;
    end
  end

  // pin mux: pwm outranks buzzer; either one forces the pin to output
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sharedOutputPin   <= 1'b0;
      sharedOutputPinOe <= 1'b0;
    end else begin
      sharedOutputPinOe <= ctrl1.pwmOutputEnable
                           || buzz.buzzerEnable;
      if (ctrl1.pwmOutputEnable) begin
        sharedOutputPin <= pwmActive ^ ctrl1.pwmActiveLow;
      end else if (buzz.buzzerEnable) begin
        sharedOutputPin <= buzzerLevel;
      end else begin
        sharedOutputPin <= 1'b0;
      end
    end
  end

  // apb slave: ready one cycle after setup, so every access takes two
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (busSetup) begin
      pready  <= 1'b1;
      pslverr <= !mapped;
      prdata  <= 32'h0000_0000;
      if (!apbReq.pwrite) begin
        unique case (apbReq.paddr)
          rdtpb_pkg::OFF_CTRL1:  prdata[7:0] <= ctrl1;
          rdtpb_pkg::OFF_CTRL2:  prdata[7:0] <= ctrl2;
          rdtpb_pkg::OFF_HIGH:   prdata[7:0] <= sharedHighBitsReg;
          rdtpb_pkg::OFF_RELOAD: prdata[9:0] <= count;
          rdtpb_pkg::OFF_DUTY:   prdata[9:0] <= pwmDutyValue;
          rdtpb_pkg::OFF_PSVAL:  prdata[7:0] <= prescalerCountValue;
          rdtpb_pkg::OFF_BUZZ:   prdata[7:0] <= buzz;
          rdtpb_pkg::OFF_IRQ: begin
            prdata[rdtpb_pkg::IRQ_FLAG_BIT] <= underflowFlag;
            prdata[rdtpb_pkg::IRQ_IE_BIT]   <= underflowIrqEnable;
            prdata[rdtpb_pkg::IRQ_GIE_BIT]  <= globalIrqEnable;
          end
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end
endmodule : rdtpb_timer

// File: rdtpb_timer_chk.sv
// port checker for the reload timer, bound into its top module
module rdtpb_timer_chk #(
  parameter int INSTR_DIV = 4
) (
  input wire logic                      clock,
  input wire logic                      sys_rst,
  input wire rdtpb_pkg::rdtpb_apb_req_t apbReq,
  input wire logic                      pready,
  input wire logic [31:0]               prdata,
  input wire logic                      pslverr,
  input wire logic                      externalClockInput,
  input wire logic                      sharedOutputPin,
  input wire logic                      sharedOutputPinOe,
  input wire logic                      pwmOutput,
  input wire logic                      buzzerOutput,
  input wire logic                      irqRequest,
  input wire logic                      underflowFlag
);
  logic       pwmEn;
  logic       buzEn;
  logic [3:0] cfgHist;
  wire logic  wrDone = apbReq.psel & apbReq.penable & pready & apbReq.pwrite;
  wire logic  clrWr = wrDone & ~apbReq.pwdata[0]
                      & (apbReq.paddr == rdtpb_pkg::OFF_IRQ);
  // outputs lag config by a register, so wait for two quiet cycles
  wire logic  cfgStable = (cfgHist == {pwmEn, buzEn, pwmEn, buzEn});

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pwmEn <= 1'b0;
      buzEn <= 1'b0;
      cfgHist <= 4'h0;
    end else begin
      if (wrDone && apbReq.paddr == rdtpb_pkg::OFF_CTRL1)
        pwmEn <= apbReq.pwdata[7];
      if (wrDone && apbReq.paddr == rdtpb_pkg::OFF_BUZZ)
        buzEn <= apbReq.pwdata[7];
      cfgHist <= {cfgHist[1:0], pwmEn, buzEn};
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence setupPh;
    apbReq.psel && !apbReq.penable;
  endsequence
  sequence accessOk;
    apbReq.psel && apbReq.penable && pready;
  endsequence

  ready_after_setup_a: assert property (setupPh |=> accessOk)
    else $error("pready missing after setup");
  ready_single_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  unmapped_err_a: assert property (apbReq.psel && !apbReq.penable
    && apbReq.paddr > rdtpb_pkg::OFF_IRQ |=> pslverr && pready)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (apbReq.psel && !apbReq.penable
    && apbReq.paddr <= rdtpb_pkg::OFF_IRQ && apbReq.paddr[1:0] == 2'h0
    |=> !pslverr) else $error("mapped access refused");
  flag_sticky_a: assert property ($fell(underflowFlag) |-> $past(clrWr))
    else $error("underflow flag cleared without software");
  irq_gate_a: assert property (irqRequest |-> $past(underflowFlag))
    else $error("irq without underflow flag");
  pin_mux_a: assert property (cfgStable |-> sharedOutputPin ==
    (pwmEn ? pwmOutput : (buzEn & buzzerOutput)))
    else $error("shared pin source wrong");
  pin_oe_a: assert property (cfgStable |->
    sharedOutputPinOe == (pwmEn | buzEn)) else $error("pin enable wrong");
endmodule : rdtpb_timer_chk

bind rdtpb_timer rdtpb_timer_chk #(.INSTR_DIV(INSTR_DIV)) i_rdtpb_timer_chk (
  .clock(clock), .sys_rst(sys_rst), .apbReq(apbReq), .pready(pready),
  .prdata(prdata), .pslverr(pslverr),
  .externalClockInput(externalClockInput), .sharedOutputPin(sharedOutputPin),
  .sharedOutputPinOe(sharedOutputPinOe), .pwmOutput(pwmOutput),
  .buzzerOutput(buzzerOutput), .irqRequest(irqRequest),
  .underflowFlag(underflowFlag));

// File: rdtpb_timer_test.sv
// register-level testbench for the reload timer
module rdtpb_timer_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic                      clock;
  logic                      sys_rst;
  rdtpb_pkg::rdtpb_apb_req_t apbReq;
  logic                      pready, pslverr, externalClockInput, pin, pinOe;
  logic                      pwmOutput, buzzerOutput, irqRequest, flag;
  logic [31:0]               prdata, rdVal, ps0;
  logic                      rdErr;
  int                        mismatches, comparisons, cycles;
  logic [7:0]                cfg [4] = '{8'h28, 8'h38, 8'h20, 8'h21};
  int                        dec [4] = '{4, 3, 2, 1};

  rdtpb_timer #(.INSTR_DIV(2)) i_rdtpb_timer (.clock(clock),
    .sys_rst(sys_rst), .apbReq(apbReq), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .externalClockInput(externalClockInput),
    .sharedOutputPin(pin), .sharedOutputPinOe(pinOe), .pwmOutput(pwmOutput),
    .buzzerOutput(buzzerOutput), .irqRequest(irqRequest),
    .underflowFlag(flag));

  always #20 clock = ~clock;

  task final_report;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report

  // hang guard: the whole run needs under a thousand cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      final_report();
    end
  end

  task check(input string what, input logic [31:0] seen, input logic [31:0] e);
    comparisons++;
    if (seen !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, seen);
    end
  endtask : check

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    apbReq <= '{1'b1, 1'b0, wr, a, d};
    @(posedge clock);
    apbReq.penable <= 1'b1;
    // no local limit: only the bench timeout ends a wait for pready
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1);
    rdVal = prdata;
    rdErr = pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask : apb

  task rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check($sformatf("reg %h", a), rdVal, e);
  endtask : rdc

  task extLevel(input logic v);
    @(posedge clock);
    externalClockInput <= v;
    repeat (3) @(posedge clock);
  endtask : extLevel

  initial begin
    clock = 1'b0;
    sys_rst = 1'b1;
    apbReq = '0;
    externalClockInput = 1'b0;
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    rdc(rdtpb_pkg::OFF_CTRL1, 32'h00);
    rdc(rdtpb_pkg::OFF_CTRL2, 32'h08);
    rdc(rdtpb_pkg::OFF_BUZZ, 32'h0f);
    rdc(rdtpb_pkg::OFF_IRQ, 32'h00);
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped error", 32'(rdErr), 32'h1);
    $display("reset values done");
    apb(1'b1, rdtpb_pkg::OFF_HIGH, 32'h20);
    apb(1'b1, rdtpb_pkg::OFF_RELOAD, 32'h34);
    rdc(rdtpb_pkg::OFF_RELOAD, 32'h234);
    repeat (20) @(posedge clock);
    rdc(rdtpb_pkg::OFF_RELOAD, 32'h234);
    $display("disabled load done");
    apb(1'b1, rdtpb_pkg::OFF_HIGH, 32'h00);
    apb(1'b1, rdtpb_pkg::OFF_RELOAD, 32'h05);
    apb(1'b1, rdtpb_pkg::OFF_IRQ, 32'h06);
    apb(1'b1, rdtpb_pkg::OFF_CTRL1, 32'h05);
    repeat (40) @(posedge clock);
    rdc(rdtpb_pkg::OFF_RELOAD, 32'h000);
    rdc(rdtpb_pkg::OFF_CTRL1, 32'h04);
    rdc(rdtpb_pkg::OFF_IRQ, 32'h07);
    check("irq request", 32'(irqRequest), 32'h1);
    apb(1'b1, rdtpb_pkg::OFF_IRQ, 32'h07);
    rdc(rdtpb_pkg::OFF_IRQ, 32'h07);
    apb(1'b1, rdtpb_pkg::OFF_IRQ, 32'h06);
    rdc(rdtpb_pkg::OFF_IRQ, 32'h06);
    $display("one-shot done");
    apb(1'b1, rdtpb_pkg::OFF_RELOAD, 32'h03);
    apb(1'b1, rdtpb_pkg::OFF_CTRL1, 32'h01);
    repeat (20) @(posedge clock);
    apb(1'b1, rdtpb_pkg::OFF_CTRL1, 32'h00);
    apb(1'b0, rdtpb_pkg::OFF_RELOAD, 32'h0);
    check("wrap count", 32'(rdVal > 32'h3e0), 32'h1);
    apb(1'b1, rdtpb_pkg::OFF_RELOAD, 32'h10);
    apb(1'b1, rdtpb_pkg::OFF_CTRL1, 32'h03);
    apb(1'b1, rdtpb_pkg::OFF_RELOAD, 32'h30);
    apb(1'b0, rdtpb_pkg::OFF_RELOAD, 32'h0);
    check("deferred reload", 32'(rdVal <= 32'h10), 32'h1);
    repeat (60) @(posedge clock);
    apb(1'b0, rdtpb_pkg::OFF_RELOAD, 32'h0);
    check("reload mode", 32'(rdVal > 32'h10 && rdVal < 32'h30), 32'h1);
    $display("free-running done");
    apb(1'b1, rdtpb_pkg::OFF_DUTY, 32'h00);
    apb(1'b1, rdtpb_pkg::OFF_BUZZ, 32'h80);
    for (int pol = 0; pol < 2; pol++) begin
      apb(1'b1, rdtpb_pkg::OFF_CTRL1, 32'h83 | 32'(pol << 6));
      repeat (3) @(posedge clock);
      repeat (30) begin
        @(posedge clock);
        check("pwm level", 32'(pwmOutput), 32'(pol));
        check("pin level", 32'(pin), 32'(pol));
      end
    end
    apb(1'b1, rdtpb_pkg::OFF_CTRL1, 32'h03);
    repeat (3) @(posedge clock);
    repeat (30) begin
      @(posedge clock);
      check("buzzer on pin", 32'(pin), 32'(buzzerOutput));
      check("buzzer pin enable", 32'(pinOe), 32'h1);
    end
    apb(1'b1, rdtpb_pkg::OFF_BUZZ, 32'h00);
    // stopped timer has no underflow, so the new duty must wait
    apb(1'b1, rdtpb_pkg::OFF_CTRL1, 32'h00);
    apb(1'b1, rdtpb_pkg::OFF_DUTY, 32'h08);
    rdc(rdtpb_pkg::OFF_DUTY, 32'h000);
    apb(1'b1, rdtpb_pkg::OFF_CTRL1, 32'h03);
    repeat (120) @(posedge clock);
    rdc(rdtpb_pkg::OFF_DUTY, 32'h008);
    $display("pwm and buzzer done");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, rdtpb_pkg::OFF_CTRL1, 32'h00);
      extLevel(1'b0);
      apb(1'b1, rdtpb_pkg::OFF_CTRL2, 32'(cfg[i]));
      apb(1'b1, rdtpb_pkg::OFF_RELOAD, 32'h0a);
      apb(1'b0, rdtpb_pkg::OFF_PSVAL, 32'h0);
      ps0 = rdVal;
      apb(1'b1, rdtpb_pkg::OFF_CTRL1, 32'h01);
      repeat (4) @(posedge clock);
      for (int k = 0; k < 4; k++) begin
        extLevel(1'b1);
        if (k < 3)
          extLevel(1'b0);
      end
      repeat (4) @(posedge clock);
      apb(1'b1, rdtpb_pkg::OFF_CTRL1, 32'h00);
      rdc(rdtpb_pkg::OFF_RELOAD, 32'(10 - dec[i]));
      apb(1'b0, rdtpb_pkg::OFF_PSVAL, 32'h0);
      if (i >= 2)
        check("prescaler count", rdVal - ps0, 32'h4);
    end
    $display("external clock done");
    final_report();
  end
endmodule : rdtpb_timer_test
